/* verilog/cfi_regs.svh */
// cfi: selector encodings, field positions and field values
`ifndef CFI_REGS_SVH
`define CFI_REGS_SVH

// common selector fields of the whole bank
`define CFI_OP0 2'h3
`define CFI_OP1 3'h0
`define CFI_CRN 4'h0

// per-register selector fields
`define CFI_CRM_ISA 4'h2
`define CFI_OP2_ISA5 3'h5
`define CFI_OP2_MMW4 3'h6
`define CFI_CRM_PFW 4'h4
`define CFI_OP2_PFW0 3'h0
// second wide word moved off the shared encoding
`define CFI_OP2_PFW1 3'h1

// exception level that is refused
`define CFI_EL_USER 2'h0

// attribute word field positions (low bit of each nibble)
`define CFI_ISA_CRC_LSB 16
`define CFI_ISA_SHA2_LSB 12
`define CFI_ISA_SHA1_LSB 8
`define CFI_ISA_AES_LSB 4
`define CFI_ISA_SEND_EVENT_LOCAL_FIELD_LSB 0

// attribute word field values
`define CFI_CRC_VAL 4'h1
`define CFI_SHA2_ON 4'h1
`define CFI_SHA1_ON 4'h1
`define CFI_AES_ON 4'h2
`define CFI_CRYPTO_OFF 4'h0
`define CFI_SEND_EVENT_LOCAL_FIELD_VAL 4'h1

// wide feature word field positions
`define CFI_PF_FAULTING_LOAD_CACHE_SAFETY_LSB 60
`define CFI_PF_BRANCH_CONTEXT_ISOLATION_LSB 56
`define CFI_PF_ICI_LSB 24
`define CFI_PF_VEC_LSB 20
`define CFI_PF_FLT_LSB 16
`define CFI_PF_ELH_LSB 0

// wide feature word field values
`define CFI_FAULTING_LOAD_CACHE_SAFETY_VAL 4'h1
`define CFI_BRANCH_CONTEXT_ISOLATION_VAL 4'h1
`define CFI_ICI_ON 4'h1
`define CFI_ICI_OFF 4'h0
`define CFI_FPSIMD_VAL 4'h0
`define CFI_ELH_VAL 4'h2

// number of exception-level handling nibbles
`define CFI_ELH_COUNT 4
// settle count reached before the pin filter is trusted; ready rises on the edge after it
`define CFI_SETTLE_CYCLES 2'h3
// nibble width
`define CFI_NIB 4

`endif

/* verilog/cfi_pkg.sv */
// cfi: types shared by the feature id bank
package cfi_pkg;

   // bank phase after reset
   typedef enum logic [0:0] {
      CFI_SETTLE,
      CFI_READY
   } cfi_phase_e;

   // why a request was refused
   typedef enum logic [1:0] {
      CFI_OK,
      CFI_LOW_LEVEL,
      CFI_WRITE,
      CFI_UNMAPPED
   } cfi_cause_e;

   // whole state of the bank
   typedef struct packed {
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic ici_disable;
      logic [1:0] settle_cnt;
      cfi_phase_e phase;
      logic ready;
      logic ack;
      logic [63:0] rdata;
      logic fault;
      cfi_cause_e cause;
   } cfi_state_s;

endpackage

/* verilog/cfi_bank.sv */
// cfi: read-only processor feature identification bank
`timescale 1ns/10ps

`include "cfi_regs.svh"

module cfi_bank #(
   parameter bit CRYPTO_PRESENT = 1'b0
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sr_rd_req,
   input wire logic sr_wr_req,
   input wire logic [1:0] sr_op0,
   input wire logic [2:0] sr_op1,
   input wire logic [3:0] sr_crn,
   input wire logic [3:0] sr_crm,
   input wire logic [2:0] sr_op2,
   input wire logic [1:0] sr_el,
   input wire logic interrupt_interface_disable_in,
   output logic sr_ready,
   output logic sr_ack,
   output logic [63:0] sr_rdata,
   output logic sr_fault,
   output cfi_pkg::cfi_cause_e sr_fault_cause
);
   import cfi_pkg::*;

   // reset image of the whole state
   localparam cfi_state_s CFI_RESET_STATE = '{
      pin_s1: 1'b0,
      pin_s2: 1'b0,
      pin_s3: 1'b0,
      ici_disable: 1'b0,
      settle_cnt: 2'h0,
      phase: CFI_SETTLE,
      ready: 1'b0,
      ack: 1'b0,
      rdata: 64'h0,
      fault: 1'b0,
      cause: CFI_OK
   };

   cfi_state_s q;
   cfi_state_s next_q;

   // build-time crypto fields, chosen together
   logic [3:0] sha2_val;
   logic [3:0] sha1_val;
   logic [3:0] aes_val;

   // live words, rebuilt every cycle from constants and the pin
   logic [31:0] isa_attribute_word5;
   logic [31:0] memory_model_word4;
   logic [63:0] wide_processor_feature_word0;
   logic [63:0] wide_processor_feature_word1;

   // named feature fields of the wide word, and the attribute word's send-event field
   logic [3:0] faulting_load_cache_safety;
   logic [3:0] branch_context_isolation;
   logic [3:0] interrupt_cpu_interface_present;
   logic [3:0] vector_unit_field;
   logic [3:0] float_unit_field;
   logic [3:0] send_event_local_field;
   logic [15:0] level_handling;

   // selector decode
   logic sel_common;
   logic hit_isa5;
   logic hit_mmw4;
   logic hit_pfw0;
   logic hit_pfw1;
   logic hit_any;
   logic low_level;
   logic req_taken;

   // crypto option fields all follow the one parameter
   always_comb begin
      if (CRYPTO_PRESENT) begin
         sha2_val = `CFI_SHA2_ON;
         sha1_val = `CFI_SHA1_ON;
         aes_val = `CFI_AES_ON;
      end else begin
         sha2_val = `CFI_CRYPTO_OFF;
         sha1_val = `CFI_CRYPTO_OFF;
         aes_val = `CFI_CRYPTO_OFF;
      end
   end

   // fixed single-value fields
   assign send_event_local_field = `CFI_SEND_EVENT_LOCAL_FIELD_VAL;
   assign faulting_load_cache_safety = `CFI_FAULTING_LOAD_CACHE_SAFETY_VAL;
   assign branch_context_isolation = `CFI_BRANCH_CONTEXT_ISOLATION_VAL;

   // interface field tracks the filtered disable pin
   always_comb begin
      if (q.ici_disable) begin
         interrupt_cpu_interface_present = `CFI_ICI_OFF;
      end else begin
         interrupt_cpu_interface_present = `CFI_ICI_ON;
      end
   end

   // one source feeds both units so they can never differ
   assign vector_unit_field = `CFI_FPSIMD_VAL;
   assign float_unit_field = vector_unit_field;

   // one nibble per exception level, all the same value
   genvar gi;
   generate
      for (gi = 0; gi < `CFI_ELH_COUNT; gi = gi + 1) begin : g_elh
         assign level_handling[gi*`CFI_NIB +: `CFI_NIB] =
            `CFI_ELH_VAL;
      end
   endgenerate

   // attribute word; unlisted upper bits stay zero
   always_comb begin
      isa_attribute_word5 = 32'h0;
      isa_attribute_word5[`CFI_ISA_CRC_LSB +: `CFI_NIB] =
         `CFI_CRC_VAL;
      isa_attribute_word5[`CFI_ISA_SHA2_LSB +: `CFI_NIB] =
         sha2_val;
      isa_attribute_word5[`CFI_ISA_SHA1_LSB +: `CFI_NIB] =
         sha1_val;
      isa_attribute_word5[`CFI_ISA_AES_LSB +: `CFI_NIB] =
         aes_val;
      isa_attribute_word5[`CFI_ISA_SEND_EVENT_LOCAL_FIELD_LSB +: `CFI_NIB] =
         send_event_local_field;
   end

   // memory-model word is entirely reserved
   assign memory_model_word4 = 32'h0;

   // wide feature word; bits 55..28 left at zero
   always_comb begin
      wide_processor_feature_word0 = 64'h0;
      wide_processor_feature_word0[`CFI_PF_FAULTING_LOAD_CACHE_SAFETY_LSB +: `CFI_NIB] =
         faulting_load_cache_safety;
      wide_processor_feature_word0[`CFI_PF_BRANCH_CONTEXT_ISOLATION_LSB +: `CFI_NIB] =
         branch_context_isolation;
      wide_processor_feature_word0[`CFI_PF_ICI_LSB +: `CFI_NIB] =
         interrupt_cpu_interface_present;
      wide_processor_feature_word0[`CFI_PF_VEC_LSB +: `CFI_NIB] =
         vector_unit_field;
      wide_processor_feature_word0[`CFI_PF_FLT_LSB +: `CFI_NIB] =
         float_unit_field;
      wide_processor_feature_word0[`CFI_PF_ELH_LSB +:
         `CFI_ELH_COUNT*`CFI_NIB] =
         level_handling;
   end

   // second wide word is entirely reserved
   assign wide_processor_feature_word1 = 64'h0;

   // shared part of every selector in this bank
   assign sel_common = (sr_op0 == `CFI_OP0) &&
                       (sr_op1 == `CFI_OP1) &&
                       (sr_crn == `CFI_CRN);

   // per-register selector match
   assign hit_isa5 = sel_common && (sr_crm == `CFI_CRM_ISA) &&
                     (sr_op2 == `CFI_OP2_ISA5);
   assign hit_mmw4 = sel_common && (sr_crm == `CFI_CRM_ISA) &&
                     (sr_op2 == `CFI_OP2_MMW4);
   assign hit_pfw0 = sel_common && (sr_crm == `CFI_CRM_PFW) &&
                     (sr_op2 == `CFI_OP2_PFW0);
   // distinct op2 avoids two words on one selector
   assign hit_pfw1 = sel_common && (sr_crm == `CFI_CRM_PFW) &&
                     (sr_op2 == `CFI_OP2_PFW1);
   assign hit_any = hit_isa5 || hit_mmw4 || hit_pfw0 || hit_pfw1;

   // user level never sees the bank; levels 1..3 do once it is ready
   assign low_level = (sr_el == `CFI_EL_USER);

   // a request counts only once the pin filter has settled
   assign req_taken = q.ready && (sr_rd_req || sr_wr_req);

   // next-state logic for the whole bank
   always_comb begin
      next_q = q;
      next_q.ack = 1'b0;

      // three-stage pin capture; only stage one reads the pin
      next_q.pin_s1 = interrupt_interface_disable_in;
      next_q.pin_s2 = q.pin_s1;
      next_q.pin_s3 = q.pin_s2;
      // accept a change only when stages two and three agree
      if (q.pin_s2 == q.pin_s3) begin
         next_q.ici_disable = q.pin_s3;
      end

      // hold off requests until the filter holds a real pin value
      case (q.phase)
         CFI_SETTLE: begin
            next_q.ready = 1'b0;
            if (q.settle_cnt == `CFI_SETTLE_CYCLES) begin
               next_q.phase = CFI_READY;
               next_q.ready = 1'b1;
            end else begin
               next_q.settle_cnt = q.settle_cnt + 2'h1;
            end
         end
         CFI_READY: begin
            next_q.ready = 1'b1;
         end
         default: begin
            next_q.phase = CFI_SETTLE;
            next_q.ready = 1'b0;
         end
      endcase

      // answer each taken request one cycle later
      if (req_taken) begin
         next_q.ack = 1'b1;
         next_q.rdata = 64'h0;
         next_q.fault = 1'b1;
         // level check first: user code learns nothing else
         if (low_level) begin
            next_q.cause = CFI_LOW_LEVEL;
         end else if (!hit_any) begin
            next_q.cause = CFI_UNMAPPED;
         end else if (sr_wr_req) begin
            // nothing is stored; a write only reports refusal
            next_q.cause = CFI_WRITE;
         end else begin
            next_q.fault = 1'b0;
            next_q.cause = CFI_OK;
            if (hit_isa5) begin
               next_q.rdata = {32'h0, isa_attribute_word5};
            end else if (hit_mmw4) begin
               next_q.rdata = {32'h0, memory_model_word4};
            end else if (hit_pfw0) begin
               next_q.rdata = wide_processor_feature_word0;
            end else begin
               next_q.rdata = wide_processor_feature_word1;
            end
         end
      end
   end

   // single register for all state
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q <= CFI_RESET_STATE;
      end else begin
         q <= next_q;
      end
   end

   // every output is a flip-flop of the state
   assign sr_ready = q.ready;
   assign sr_ack = q.ack;
   assign sr_rdata = q.rdata;
   assign sr_fault = q.fault;
   assign sr_fault_cause = q.cause;

endmodule

/* tb/cfi_bank_assertions.sv */
// cfi: port-level checks on the feature id bank
`timescale 1ns/10ps
module cfi_bank_assertions #(
   parameter bit CRYPTO_PRESENT = 1'b0
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sr_rd_req,
   input wire logic sr_wr_req,
   input wire logic [1:0] sr_op0,
   input wire logic [2:0] sr_op1,
   input wire logic [3:0] sr_crn,
   input wire logic [3:0] sr_crm,
   input wire logic [2:0] sr_op2,
   input wire logic [1:0] sr_el,
   input wire logic interrupt_interface_disable_in,
   input wire logic sr_ready,
   input wire logic sr_ack,
   input wire logic [63:0] sr_rdata,
   input wire logic sr_fault,
   input cfi_pkg::cfi_cause_e sr_fault_cause
);
   import cfi_pkg::*;
   logic [15:0] sel;
   logic mapped;
   logic pin_q;
   logic [2:0] quiet;
   // whole selector, and whether it names one of the four words
   assign sel = {sr_op0, sr_op1, sr_crn, sr_crm, sr_op2};
   assign mapped = sel inside {16'hC015, 16'hC016, 16'hC020, 16'hC021};
   // pin goes through a filter, so trust it only after a quiet spell
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pin_q <= 1'b0;
         quiet <= 3'h0;
      end else begin
         pin_q <= interrupt_interface_disable_in;
         if (pin_q != interrupt_interface_disable_in) quiet <= 3'h0;
         else if (quiet != 3'h7) quiet <= quiet + 3'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence take_s;
      sr_ready && (sr_rd_req || sr_wr_req);
   endsequence
   sequence read_s;
      take_s ##0 !sr_wr_req && sr_el != 2'h0;
   endsequence
   answer_next_a: assert property (take_s |=> sr_ack)
      else $error("request not answered next cycle");
   lone_ack_a: assert property (sr_ack |-> $past(sr_ready)
      && $past(sr_rd_req || sr_wr_req)) else $error("answer without request");
   low_level_a: assert property (take_s ##0 sr_el == 2'h0 |=> sr_fault
      && sr_fault_cause == CFI_LOW_LEVEL && sr_rdata == 64'h0)
      else $error("level zero read not refused");
   isa_word_a: assert property (read_s ##0 sel == 16'hC015 |=> !sr_fault
      && sr_rdata == (CRYPTO_PRESENT ? 64'h11121 : 64'h10001))
      else $error("attribute word wrong");
   zero_words_a: assert property (read_s ##0 sel inside {16'hC016,
      16'hC021} |=> !sr_fault && sr_rdata == 64'h0)
      else $error("reserved word not zero");
   feature_word_a: assert property (read_s ##0 sel == 16'hC020 |=>
      !sr_fault && sr_rdata[63:28] == 36'h110000000
      && sr_rdata[23:0] == 24'h2222) else $error("feature word wrong");
   vec_float_a: assert property (read_s ##0 sel == 16'hC020 |=>
      sr_rdata[23:20] == sr_rdata[19:16]) else $error("unit fields differ");
   pin_field_a: assert property (read_s ##0 sel == 16'hC020 &&
      quiet == 3'h7 |=> sr_rdata[27:24] ==
      {3'h0, !$past(interrupt_interface_disable_in)})
      else $error("interface field does not follow pin");
   write_refused_a: assert property (take_s ##0 sr_wr_req &&
      sr_el != 2'h0 && mapped |=> sr_fault && sr_fault_cause == CFI_WRITE)
      else $error("write not refused");
   unmapped_select_a: assert property (take_s ##0 sr_el != 2'h0
      && !mapped
      |=> sr_fault_cause == CFI_UNMAPPED) else $error("unmapped not refused");
endmodule

bind cfi_bank cfi_bank_assertions #(.CRYPTO_PRESENT(CRYPTO_PRESENT))
   cfi_bank_assertions_i (.core_clk(core_clk), .resetn(resetn),
   .sr_rd_req(sr_rd_req), .sr_wr_req(sr_wr_req), .sr_op0(sr_op0),
   .sr_op1(sr_op1), .sr_crn(sr_crn), .sr_crm(sr_crm), .sr_op2(sr_op2),
   .sr_el(sr_el), .sr_ready(sr_ready), .sr_ack(sr_ack),
   .interrupt_interface_disable_in(interrupt_interface_disable_in),
   .sr_rdata(sr_rdata), .sr_fault(sr_fault),
   .sr_fault_cause(sr_fault_cause));

/* tb/cfi_bank_tb.sv */
// cfi: self-checking bench, both build options side by side
`timescale 1ns/10ps
module cfi_bank_tb;
   import cfi_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic rd = 1'b1;
   logic wr = 1'b0;
   logic dis = 1'b0;
   logic [15:0] sel = 16'hC015;
   logic [1:0] el = 2'h1;
   logic [1:0] rdy, ack, flt;
   logic [63:0] dat [2];
   cfi_cause_e cau [2];
   logic [15:0] sl [5] = '{16'hC015, 16'hC016, 16'hC020, 16'hC021, 16'hC014};
   int n_errors = 0;
   int tests_run = 0;
   always #25 core_clk = ~core_clk;
   // instance 0 without crypto, instance 1 with it
   for (genvar g = 0; g < 2; g++) begin : gb
      cfi_bank #(.CRYPTO_PRESENT(g == 1)) cfi_bank_i (.core_clk(core_clk),
         .resetn(resetn), .sr_rd_req(rd), .sr_wr_req(wr), .sr_el(el),
         .sr_op0(sel[15:14]), .sr_op1(sel[13:11]), .sr_crn(sel[10:7]),
         .sr_crm(sel[6:3]), .sr_op2(sel[2:0]), .sr_ready(rdy[g]),
         .interrupt_interface_disable_in(dis), .sr_ack(ack[g]),
         .sr_rdata(dat[g]), .sr_fault(flt[g]), .sr_fault_cause(cau[g]));
   end
   task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // answer {ack, fault, cause, data}; level, then unmapped, then write
   function automatic logic [67:0] expv(logic [15:0] s, logic [1:0] l,
         logic w, logic cr, logic d);
      logic [63:0] v;
      logic [1:0] c;
      v = 64'h0;
      if (s == 16'hC015) v = cr ? 64'h11121 : 64'h10001;
      if (s == 16'hC020) v = {8'h11, 28'h0, 3'h0, !d, 24'h2222};
      c = l == 2'h0 ? 2'h1 : w ? 2'h2 : 2'h0;
      // a selector outside the bank outranks a write
      if (l != 2'h0 &&
            !(s inside {16'hC015, 16'hC016, 16'hC020, 16'hC021}))
         c = 2'h3;
      return {1'b1, c != 2'h0, c, c != 2'h0 ? 64'h0 : v};
   endfunction
   // called at a falling edge; holds the request so calls run back to back
   task automatic req(logic [15:0] s, logic [1:0] l, logic w);
      logic [67:0] e [2];
      sel = s;
      el = l;
      wr = w;
      rd = !w | 1'($urandom);
      for (int i = 0; i < 2; i++) e[i] = expv(s, l, w, i == 1, dis);
      @(negedge core_clk);
      for (int i = 0; i < 2; i++)
         chk({ack[i], flt[i], cau[i], dat[i]},
            e[i]);
   endtask
   // releases reset; nothing answered before ready, which takes 4 edges
   task automatic settle;
      int n;
      n = 0;
      resetn = 1'b1;
      while (n < 20 && rdy !== 2'h3) begin
         chk({66'h0, ack}, 68'h0);
         n++;
         @(negedge core_clk);
      end
      chk(68'(n), 68'h4);
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a hang is cut short at about five times the expected run length
   initial begin
      #100000;
      n_errors++;
      final_report;
   end
   initial begin
      void'($urandom(32'hDF3935E1));
      repeat (6) @(negedge core_clk);
      // request held through settling must stay unanswered
      settle;
      // every word, every level, read and write
      foreach (sl[j])
         for (int i = 0; i < 8; i++) req(sl[j], 2'(i), i >= 4);
      // random traffic under each pin level, after the filter settles
      for (int p = 0; p < 2; p++) begin
         rd = 1'b0;
         wr = 1'b0;
         dis = p == 0;
         repeat (8) @(negedge core_clk);
         repeat (150)
            req($urandom % 4 == 0 ? 16'($urandom) : sl[$urandom % 5],
               2'($urandom), $urandom % 4 == 0);
      end
      // reset in mid-run clears the answer
      resetn = 1'b0;
      @(negedge core_clk);
      chk({ack, flt, dat[1]}, 68'h0);
      chk({rdy, cau[0], cau[1]}, 68'h0);
      // leftover request stays held through the second settling
      settle;
      req(16'hC020, 2'h3, 1'b0);
      final_report;
   end
endmodule
